/* src/tws_pkg.sv */
package tws_pkg;

	// ==========================================
	// Register indices on the plain port
	localparam logic [2:0] OFS_OWN_ADDR = 3'h0;
	localparam logic [2:0] OFS_CTRL = 3'h1;
	localparam logic [2:0] OFS_STATUS = 3'h2;
	localparam logic [2:0] OFS_DATA = 3'h3;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h4;
	localparam logic [2:0] OFS_IRQ_STAT = 3'h5;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;

	// ==========================================
	// Status codes, prescaler field always zero
	localparam logic [7:0] ST_OWN_READ = 8'hA8;
	localparam logic [7:0] ST_ARB_READ = 8'hB0;
	localparam logic [7:0] ST_SENT_ACK = 8'hB8;
	localparam logic [7:0] ST_SENT_NACK = 8'hC0;
	localparam logic [7:0] ST_LAST_ACK = 8'hC8;
	localparam logic [7:0] ST_NO_INFO = 8'hF8;

	// ==========================================
	// Bus constants
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam int IRQ_STEP = 0;
	localparam int IRQ_WAKE = 1;

	// ==========================================
	// Control register layout
	typedef struct packed {
		logic step_done_flag;
		logic ack_enable;
		logic start_request;
		logic stop_request;
		logic rsv3;
		logic interface_enable;
		logic rsv1;
		logic rsv0;
	} tws_ctrl_s;

	// Own address register layout
	typedef struct packed {
		logic [6:0] slave_addr_field;
		logic general_call_enable;
	} tws_own_s;

	// Synchronised pin levels and edges
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic sda_rise;
		logic sda_fall;
	} tws_pins_s;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_AACK = 3'b010,
		S_HOLD = 3'b011,
		S_TXBIT = 3'b100,
		S_TXACK = 3'b101,
		S_RX = 3'b110
	} tws_state_e;

endpackage : tws_pkg

/* src/tws_pin_sync.sv */
`timescale 1ns/1ps
module tws_pin_sync (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// Raw bus lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Clean levels and edges
	output tws_pkg::tws_pins_s pins
);

	// ==========================================
	// Two-flop synchroniser plus one history stage
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic [1:0] hist_reg;

	// Idle bus reads high, so no false edge after reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			hist_reg <= 2'h3;
		end else if (ce) begin
			meta_reg <= {scl_in, sda_in};
			sync_reg <= meta_reg;
			hist_reg <= sync_reg;
		end
	end

	assign pins.scl = sync_reg[1];
	assign pins.sda = sync_reg[0];
	assign pins.scl_rise = sync_reg[1] & ~hist_reg[1];
	assign pins.scl_fall = ~sync_reg[1] & hist_reg[1];
	assign pins.sda_rise = sync_reg[0] & ~hist_reg[0];
	assign pins.sda_fall = ~sync_reg[0] & hist_reg[0];

endmodule : tws_pin_sync

/* src/tws_slave_tx.sv */
`timescale 1ns/1ps
module tws_slave_tx (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Bus clock line, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// Bus data line, open drain
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// System side
	input wire logic sleep_deep,
	input wire logic arb_lost,
	output logic wake_req,
	output logic slave_receive_mode,
	output logic irq
);

	// ==========================================
	// Pin synchroniser
	tws_pkg::tws_pins_s pins;

	tws_pin_sync u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.pins(pins)
	);

	// ==========================================
	// State
	tws_pkg::tws_state_e state_reg, state_next;
	tws_pkg::tws_own_s own_reg;
	tws_pkg::tws_ctrl_s ctrl_reg;
	logic flag_reg, flag_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] data_reg;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] cnt_reg, cnt_next;
	logic last_reg, last_next;
	logic end_reg, end_next;
	logic ack_reg, ack_next;
	logic wake_reg, wake_next;
	logic rxm_reg, rxm_next;
	logic [1:0] imask_reg;
	logic [1:0] istat_reg;
	logic [7:0] rdata_reg;
	logic irq_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;

	// ==========================================
	// Register decode
	wire wr_own = reg_wr && (reg_addr == tws_pkg::OFS_OWN_ADDR);
	wire wr_ctrl = reg_wr && (reg_addr == tws_pkg::OFS_CTRL);
	wire wr_data = reg_wr && (reg_addr == tws_pkg::OFS_DATA);
	wire wr_imask = reg_wr && (reg_addr == tws_pkg::OFS_IRQ_MASK);
	wire rd_istat = reg_rd && (reg_addr == tws_pkg::OFS_IRQ_STAT);
	wire tws_pkg::tws_ctrl_s ctrl_wr = reg_wdata;
	// Writing a one clears the flag
	wire flag_clr = wr_ctrl && ctrl_wr.step_done_flag;
	// Prescaler bits are absent and read zero
	wire [7:0] status_view = flag_reg ? status_reg : tws_pkg::ST_NO_INFO;
	wire [7:0] ctrl_view = {flag_reg, ctrl_reg[6:0]};
	wire [7:0] rd_mux;
	assign rd_mux = (reg_addr == tws_pkg::OFS_OWN_ADDR) ? own_reg :
		(reg_addr == tws_pkg::OFS_CTRL) ? ctrl_view :
		(reg_addr == tws_pkg::OFS_STATUS) ? status_view :
		(reg_addr == tws_pkg::OFS_DATA) ? data_reg :
		(reg_addr == tws_pkg::OFS_IRQ_MASK) ? {6'h00, imask_reg} :
		(reg_addr == tws_pkg::OFS_IRQ_STAT) ? {6'h00, istat_reg} :
		tws_pkg::RD_UNMAPPED;

	// ==========================================
	// Bus conditions and address match
	wire enabled = ctrl_reg.interface_enable;
	wire start_seen = pins.sda_fall && pins.scl;
	wire stop_seen = pins.sda_rise && pins.scl;
	wire [6:0] rx_addr = shift_reg[7:1];
	wire rx_read = shift_reg[0];
	wire own_hit = (rx_addr == own_reg.slave_addr_field);
	// General call carries no read; a read to it is ignored
	wire gc_hit = own_reg.general_call_enable && !rx_read &&
		(rx_addr == tws_pkg::GENERAL_CALL_ADDR);
	// Ack enable low isolates us without losing bus tracking
	wire addr_match = ctrl_reg.ack_enable && (own_hit || gc_hit);
	wire byte_done = (cnt_reg == tws_pkg::BYTE_BITS);
	wire flag_set = (state_next == tws_pkg::S_HOLD) && (state_reg != tws_pkg::S_HOLD);

	// ==========================================
	// Bus state machine
	always_comb begin
		state_next = state_reg;
		status_next = status_reg;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		last_next = last_reg;
		end_next = end_reg;
		ack_next = ack_reg;
		rxm_next = rxm_reg;
		case (state_reg)
			tws_pkg::S_IDLE: begin
				rxm_next = 1'b0;
			end
			tws_pkg::S_ADDR: begin
				if (pins.scl_rise && !byte_done) begin
					shift_next = {shift_reg[6:0], pins.sda};
					cnt_next = cnt_reg + tws_pkg::CNT_ONE;
				end else if (pins.scl_fall && byte_done) begin
					state_next = addr_match ? tws_pkg::S_AACK : tws_pkg::S_IDLE;
				end
			end
			tws_pkg::S_AACK: begin
				if (pins.scl_fall) begin
					if (rx_read) begin
						state_next = tws_pkg::S_HOLD;
						status_next = arb_lost ? tws_pkg::ST_ARB_READ :
							tws_pkg::ST_OWN_READ;
						end_next = 1'b0;
					end else begin
						state_next = tws_pkg::S_RX;
						rxm_next = 1'b1;
					end
				end
			end
			tws_pkg::S_HOLD: begin
				if (!flag_reg) begin
					if (end_reg) begin
						state_next = tws_pkg::S_IDLE;
					end else begin
						// Byte and ack enable are taken as the flag drops
						shift_next = data_reg;
						last_next = !ctrl_reg.ack_enable;
						cnt_next = tws_pkg::CNT_ZERO;
						state_next = tws_pkg::S_TXBIT;
					end
				end
			end
			tws_pkg::S_TXBIT: begin
				if (pins.scl_fall) begin
					shift_next = {shift_reg[6:0], 1'b1};
					cnt_next = cnt_reg + tws_pkg::CNT_ONE;
					if (cnt_reg == tws_pkg::LAST_BIT) begin
						state_next = tws_pkg::S_TXACK;
					end
				end
			end
			tws_pkg::S_TXACK: begin
				if (pins.scl_rise) begin
					ack_next = !pins.sda;
				end else if (pins.scl_fall) begin
					state_next = tws_pkg::S_HOLD;
					if (last_reg) begin
						status_next = ack_reg ? tws_pkg::ST_LAST_ACK :
							tws_pkg::ST_SENT_NACK;
						end_next = 1'b1;
					end else begin
						status_next = ack_reg ? tws_pkg::ST_SENT_ACK :
							tws_pkg::ST_SENT_NACK;
						end_next = !ack_reg;
					end
				end
			end
			tws_pkg::S_RX: begin
				rxm_next = 1'b1;
			end
			default: begin
				state_next = tws_pkg::S_IDLE;
			end
		endcase
		// Frame edges override all but a stretched hold
		if (state_reg != tws_pkg::S_HOLD) begin
			if (start_seen) begin
				state_next = tws_pkg::S_ADDR;
				cnt_next = tws_pkg::CNT_ZERO;
				rxm_next = 1'b0;
			end else if (stop_seen) begin
				state_next = tws_pkg::S_IDLE;
				rxm_next = 1'b0;
			end
		end
		if (!enabled) begin
			state_next = tws_pkg::S_IDLE;
			rxm_next = 1'b0;
		end
	end

	// Set wins over a software clear in the same cycle
	assign flag_next = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);
	// Wake request stands until software releases the stretch
	wire wake_hit = sleep_deep && flag_set && (state_reg == tws_pkg::S_AACK);
	assign wake_next = wake_hit ? 1'b1 : (flag_clr ? 1'b0 : wake_reg);

	// ==========================================
	// Pin drive, registered so outputs never glitch
	wire scl_hold = (state_next == tws_pkg::S_HOLD) && flag_next;
	wire sda_low_ack = (state_next == tws_pkg::S_AACK);
	wire sda_low_bit = (state_next == tws_pkg::S_TXBIT) && !shift_next[7];
	wire sda_drive = sda_low_ack || sda_low_bit;

	// ==========================================
	// Interrupt status, read clears, set wins
	wire [1:0] irq_ev = {wake_hit, flag_set};
	wire [1:0] istat_next = irq_ev | (rd_istat ? 2'h0 : istat_reg);
	wire irq_next = |(istat_next & imask_reg);

	// ==========================================
	// Flops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= tws_pkg::S_IDLE;
			status_reg <= tws_pkg::ST_NO_INFO;
			shift_reg <= tws_pkg::RST_BYTE;
			cnt_reg <= tws_pkg::CNT_ZERO;
			last_reg <= 1'b0;
			end_reg <= 1'b0;
			ack_reg <= 1'b0;
			rxm_reg <= 1'b0;
			flag_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			status_reg <= status_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			last_reg <= last_next;
			end_reg <= end_next;
			ack_reg <= ack_next;
			rxm_reg <= rxm_next;
			flag_reg <= flag_next;
			wake_reg <= wake_next;
		end
	end

	// Own address, control and mask registers; control keeps only the ack, start, stop and enable bits from software
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			own_reg <= tws_pkg::RST_BYTE;
			ctrl_reg <= tws_pkg::RST_BYTE;
			imask_reg <= tws_pkg::RST_IRQ;
		end else if (ce) begin
			if (wr_own) begin
				own_reg <= reg_wdata;
			end
			if (wr_ctrl) begin
				ctrl_reg <= {1'b0, ctrl_wr.ack_enable, ctrl_wr.start_request,
					ctrl_wr.stop_request, 1'b0, ctrl_wr.interface_enable,
					2'h0};
			end
			if (wr_imask) begin
				imask_reg <= reg_wdata[1:0];
			end
		end
	end

	// Data register only ever loaded by software, never from the bus
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			data_reg <= tws_pkg::RST_BYTE;
		end else if (ce && wr_data) begin
			data_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			istat_reg <= tws_pkg::RST_IRQ;
			irq_reg <= 1'b0;
			rdata_reg <= tws_pkg::RD_UNMAPPED;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (ce) begin
			istat_reg <= istat_next;
			irq_reg <= irq_next;
			rdata_reg <= reg_rd ? rd_mux : tws_pkg::RD_UNMAPPED;
			scl_oe_reg <= scl_hold;
			sda_oe_reg <= sda_drive;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = rdata_reg;
	assign irq = irq_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	// Open drain: only ever drives low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign wake_req = wake_reg;
	assign slave_receive_mode = rxm_reg;

endmodule : tws_slave_tx

/* dv/tws_slave_tx_properties.sv */
`timescale 1ns/1ps
module tws_slave_tx_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Bus pins
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	// System side
	input wire logic sleep_deep,
	input wire logic wake_req,
	input wire logic slave_receive_mode,
	input wire logic irq
);
	// ==========================
	// Access history
	logic [2:0] acc_hist;
	always_ff @(posedge clk_sys) begin
		acc_hist <= {acc_hist[1:0], reg_rd | reg_wr};
	end
	// ==========================
	// Properties
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	rst_idle_a: assert property ($past(sys_rst) |-> reg_rdata == 8'h00 && !irq
		&& !scl_oe && !sda_oe && !wake_req && !slave_receive_mode)
		else $error("outputs busy after reset");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	stretch_free_a: assert property (scl_oe |-> !sda_oe)
		else $error("data driven while clock held");
	wake_sleep_a: assert property ($rose(wake_req) |-> $past(sleep_deep))
		else $error("wake request while awake");
	wake_hold_a: assert property ($rose(wake_req) |-> ##[0:4] scl_oe [*6])
		else $error("clock not held on wake");
	rcv_quiet_a: assert property (slave_receive_mode |-> !scl_oe && !wake_req)
		else $error("receiver handoff held clock");
	irq_clear_a: assert property ($fell(irq) |-> |acc_hist)
		else $error("interrupt dropped without access");
	outs_low_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("open drain level not low");
	cov_stretch: cover property ($rose(scl_oe));
	cov_wake: cover property ($rose(wake_req));
	cov_rcv: cover property ($rose(slave_receive_mode));
endmodule : tws_slave_tx_props

bind tws_slave_tx tws_slave_tx_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .sleep_deep(sleep_deep),
	.wake_req(wake_req), .slave_receive_mode(slave_receive_mode), .irq(irq));

/* dv/tws_master_model.sv */
`timescale 1ns/1ps
module tws_master_model (
	// Wired levels
	input wire logic scl,
	input wire logic sda,
	// Pulls, high drives low
	output logic scl_pull,
	output logic sda_pull
);
	// ==========================
	// Bus tasks
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// Data moves well after the fall, so sync skew never fakes a start
	// Pulls move by non-blocking update so no edge-time race with the sampler
	task automatic clk_bit(input logic b, output logic s);
		sda_pull <= !b;
		#70;
		scl_pull <= 1'b0;
		#1;
		for (int i = 0; i < 5000 && scl !== 1'b1; i++)
			#20;
		#24;
		s = sda;
		#25;
		scl_pull <= 1'b1;
		#40;
	endtask : clk_bit
	task automatic start_tx();
		sda_pull <= 1'b1;
		#80;
		scl_pull <= 1'b1;
		#40;
	endtask : start_tx
	// Leading gap keeps the data release of a transfer apart from the stop
	task automatic stop_tx();
		#20;
		sda_pull <= 1'b1;
		#60;
		scl_pull <= 1'b0;
		#60;
		sda_pull <= 1'b0;
		#200;
	endtask : stop_tx
	task automatic xfer(input logic [7:0] w, input logic ak, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--)
			clk_bit(w[i], r[i]);
		clk_bit(ak, a);
		sda_pull <= 1'b0;
	endtask : xfer
endmodule : tws_master_model

/* dv/tb_two_wire_slave_transmitter.sv */
`timescale 1ns/1ps
module tb_two_wire_slave_transmitter;
	// ==========================
	// Signals
	logic clk_sys = 1'b0, sys_rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic sleep_deep = 1'b0, arb_lost = 1'b0, m_scl, m_sda, scl_in, sda_in;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, wake_req, slave_receive_mode, irq;
	int miscompares = 0, num_checks = 0;
	logic [18:0] rows [7] = '{{3'h0, 8'hA5, 8'hA5}, {3'h1, 8'h7F, 8'h74},
		{3'h2, 8'h00, 8'hF8}, {3'h3, 8'h3C, 8'h3C}, {3'h4, 8'hFF, 8'h03},
		{3'h6, 8'h55, 8'h00}, {3'h7, 8'hAA, 8'h00}};
	// Pull-ups on both lines
	assign scl_in = ~(scl_oe | m_scl);
	assign sda_in = ~(sda_oe | m_sda);
	always #10 clk_sys = ~clk_sys;
	tws_slave_tx u_tws_slave_tx (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .sleep_deep(sleep_deep),
		.arb_lost(arb_lost), .wake_req(wake_req), .slave_receive_mode(slave_receive_mode),
		.irq(irq));
	tws_master_model u_master (.scl(scl_in), .sda(sda_in), .scl_pull(m_scl),
		.sda_pull(m_sda));
	// ==========================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_st(input logic [7:0] e);
		logic [7:0] s;
		s = 8'hF8;
		for (int n = 0; n < 300 && s === 8'hF8; n++)
			rd(3'h2, s);
		chk(s & 8'hF8, e);
	endtask : wait_st
	task automatic rd_byte(input logic [7:0] v, input logic [7:0] c, input logic ak,
		input logic [7:0] st);
		logic [7:0] r;
		logic a;
		wr(3'h3, v);
		wr(3'h1, c);
		u_master.xfer(8'hFF, ak, r, a);
		chk(r, v);
		wait_st(st);
	endtask : rd_byte
	task automatic addr(input logic [7:0] w, input logic [7:0] e);
		logic [7:0] r;
		logic a;
		u_master.start_tx();
		u_master.xfer(w, 1'b1, r, a);
		chk({7'h0, a}, e);
	endtask : addr
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		#1_000_000;
		miscompares++;
		end_of_test();
	end
	// ==========================
	// Sequence
	initial begin
		logic [7:0] d;
		logic a;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			wr(rows[i][18:16], rows[i][15:8]);
			rd(rows[i][18:16], d);
			chk(d, rows[i][7:0]);
		end
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(3'h0, d);
		chk(d, tws_pkg::RST_BYTE);
		rd(3'h2, d);
		chk(d, tws_pkg::ST_NO_INFO);
		wr(3'h0, 8'hA5);
		wr(3'h4, 8'h01);
		wr(3'h1, 8'h44);
		addr(8'hA7, 8'h01);
		u_master.stop_tx();
		addr(8'h00, 8'h00);
		// Ninth fall still has to pass the synchroniser
		repeat (4) @(posedge clk_sys);
		chk({7'h0, slave_receive_mode}, 8'h01);
		u_master.stop_tx();
		addr(8'hA5, 8'h00);
		wait_st(tws_pkg::ST_OWN_READ);
		chk({7'h0, irq}, 8'h01);
		rd(3'h5, d);
		chk(d, 8'h01);
		rd_byte(8'hC3, 8'hC4, 1'b0, tws_pkg::ST_SENT_ACK);
		rd_byte(8'h5A, 8'h84, 1'b0, tws_pkg::ST_LAST_ACK);
		wr(3'h1, 8'hC4);
		u_master.xfer(8'hFF, 1'b1, d, a);
		chk(d, 8'hFF);
		u_master.stop_tx();
		@(posedge clk_sys);
		arb_lost <= 1'b1;
		addr(8'hA5, 8'h00);
		wait_st(tws_pkg::ST_ARB_READ);
		rd_byte(8'h81, 8'h84, 1'b1, tws_pkg::ST_SENT_NACK);
		wr(3'h1, 8'hC4);
		u_master.stop_tx();
		wr(3'h1, 8'h04);
		addr(8'hA5, 8'h01);
		u_master.stop_tx();
		wr(3'h0, 8'hA4);
		// Ack enable back on, so only the cleared general call bit refuses
		wr(3'h1, 8'h44);
		addr(8'h00, 8'h01);
		u_master.stop_tx();
		@(posedge clk_sys);
		arb_lost <= 1'b0;
		sleep_deep <= 1'b1;
		addr(8'hA5, 8'h00);
		wait_st(tws_pkg::ST_OWN_READ);
		chk({6'h0, wake_req, scl_oe}, 8'h03);
		rd_byte(8'hE7, 8'h84, 1'b1, tws_pkg::ST_SENT_NACK);
		chk({7'h0, wake_req}, 8'h00);
		wr(3'h1, 8'hC4);
		u_master.stop_tx();
		end_of_test();
	end
endmodule : tb_two_wire_slave_transmitter
